// ==== rtl/smcp_top.sv ====
// serial memory command decoder, status protection and array, plus write buffer
// assumes a host spi master on cs_b/sck/si/wp_b pins, all asynchronous to mclk_in
`timescale 1ns/10ps
`include "smcp_defs.svh"

// =====================================================================
// write buffer between the serial side and the array
module smcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in, // core clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic [WIDTH-1:0] in_data_in, // word to store
  input wire logic in_valid_in, // word offered
  output logic in_ready_out, // room for a word
  output logic [WIDTH-1:0] out_data_out, // oldest word
  output logic out_valid_out, // a word is held
  input wire logic out_ready_in // drain takes the word
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  logic [WIDTH-1:0] store_reg [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic push, pop;

  // handshake terms and pointer updates
  always_comb begin
    push = in_valid_in & in_ready_out;
    pop = out_valid_out & out_ready_in;
    wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
    count_next = count_reg + CW'(push) - CW'(pop);
  end

  assign in_ready_out = count_reg != CW'(DEPTH);
  assign out_valid_out = count_reg != CW'(0);
  assign out_data_out = store_reg[rd_ptr_reg];

  // pointer registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // storage, no reset needed on data
  always_ff @(posedge clk_in) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data_in;
    end
  end
endmodule // smcp_fifo

// =====================================================================
// top: pin sampling, command decode, status, array
module smcp_top (
  input wire logic mclk_in, // 50 MHz core clock
  input wire logic rst_b_in, // async reset, active low, factory state
  input wire logic power_restore_in, // one-cycle pulse: supply came back
  input wire logic cs_b_in, // chip select pin, active low
  input wire logic sck_in, // serial clock pin
  input wire logic si_in, // serial data in pin
  input wire logic wp_b_in, // write protect pin, active low
  output logic so_out, // serial data out value
  output logic so_oe_out, // serial data out enable, high drives
  output logic [7:0] status_out, // current status byte
  output logic sleep_out // sleep mode active
);
  // =====================================================================
  // declarations
  smcp_pkg::smcp_pins_type s1_reg, s2_reg, s3_reg, filt_reg, filt_next, pins;
  smcp_pkg::smcp_state_type state_reg, state_next;
  smcp_pkg::smcp_wr_type push_data_reg, push_data_next, drain_word;
  logic [2:0] bitcnt_reg, bitcnt_next;
  logic [7:0] shin_reg, shin_next, shout_reg, shout_next, cmd_reg, cmd_next;
  logic [7:0] data_reg, data_next, status_reg, status_next, byte_val, load_byte;
  logic [14:0] addr_reg, addr_next;
  logic ahi_reg, ahi_next, sleep_reg, sleep_next, mode_reg, mode_next;
  logic rise_seen_reg, rise_seen_next, so_reg, so_next, so_oe_reg, so_oe_next;
  logic push_v_reg, push_v_next, fifo_ready, drain_valid, drain_ready;
  logic sck_rise, sck_fall, cs_fall, cs_rise, cs_act, byte_done, exec_go;
  logic load_go, sr_write_go, wr_allowed;
  logic [7:0] mem_reg [0:`SMCP_MEM_DEPTH-1];

  // protection decode of one address
  function automatic logic addr_guarded(input logic [1:0] bp, input logic [14:0] a);
    case (bp)
      `SMCP_BP_NONE: addr_guarded = 1'b0;
      `SMCP_BP_QUARTER: addr_guarded = a >= `SMCP_QUARTER_BASE;
      `SMCP_BP_HALF: addr_guarded = a >= `SMCP_HALF_BASE;
      default: addr_guarded = 1'b1;
    endcase
  endfunction

  // =====================================================================
  // pin synchroniser: three stages, level taken when stages two and three agree
  assign pins = '{cs_b: cs_b_in, sck: sck_in, si: si_in, wp_b: wp_b_in};
  for (genvar g = 0; g < 4; g++) begin : g_filt
    assign filt_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : filt_reg[g];
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_reg <= '{cs_b: 1'b1, sck: 1'b0, si: 1'b0, wp_b: 1'b1};
      s2_reg <= '{cs_b: 1'b1, sck: 1'b0, si: 1'b0, wp_b: 1'b1};
      s3_reg <= '{cs_b: 1'b1, sck: 1'b0, si: 1'b0, wp_b: 1'b1};
      filt_reg <= '{cs_b: 1'b1, sck: 1'b0, si: 1'b0, wp_b: 1'b1};
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // edge events of the filtered levels
  always_comb begin
    cs_act = !filt_reg.cs_b;
    cs_fall = filt_reg.cs_b & !filt_next.cs_b;
    cs_rise = !filt_reg.cs_b & filt_next.cs_b;
    sck_rise = cs_act & !cs_rise & !filt_reg.sck & filt_next.sck;
    sck_fall = cs_act & !cs_rise & filt_reg.sck & !filt_next.sck;
    byte_done = sck_rise & (bitcnt_reg == `SMCP_BIT_LAST);
    byte_val = {shin_reg[6:0], filt_next.si};
    exec_go = cs_rise & (state_reg == smcp_pkg::ST_ARM) & (bitcnt_reg == `SMCP_BIT_FIRST);
    wr_allowed = status_reg[`SMCP_BIT_WEL] & (!status_reg[`SMCP_BIT_SWD] | filt_reg.wp_b);
    sr_write_go = exec_go & (cmd_reg == `SMCP_OP_STAT_WR) & wr_allowed;
    load_go = sck_fall & (!mode_reg | rise_seen_reg) & (bitcnt_reg == `SMCP_BIT_FIRST) &
      ((state_reg == smcp_pkg::ST_RDATA) | (state_reg == smcp_pkg::ST_SRD));
    load_byte = (state_reg == smcp_pkg::ST_SRD) ? status_reg : mem_reg[addr_reg];
    drain_ready = !load_go; // array port busy while a read byte is fetched
  end

  // =====================================================================
  // command sequencer next state
  always_comb begin
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    shin_next = shin_reg;
    shout_next = shout_reg;
    cmd_next = cmd_reg;
    data_next = data_reg;
    addr_next = addr_reg;
    ahi_next = ahi_reg;
    status_next = status_reg;
    sleep_next = sleep_reg;
    mode_next = mode_reg;
    rise_seen_next = rise_seen_reg;
    so_next = so_reg;
    so_oe_next = so_oe_reg;
    push_v_next = push_v_reg & !fifo_ready;
    push_data_next = push_data_reg;
    if (cs_fall) begin
      state_next = smcp_pkg::ST_CMD;
      bitcnt_next = `SMCP_BIT_FIRST;
      ahi_next = 1'b0;
      mode_next = filt_reg.sck;
      rise_seen_next = 1'b0;
    end else if (!cs_act || cs_rise) begin
      state_next = smcp_pkg::ST_IDLE;
      so_oe_next = 1'b0;
      if (exec_go) begin
        case (cmd_reg)
          `SMCP_OP_LATCH_SET: status_next[`SMCP_BIT_WEL] = 1'b1;
          `SMCP_OP_LATCH_CLR: status_next[`SMCP_BIT_WEL] = 1'b0;
          `SMCP_OP_SLEEP: sleep_next = 1'b1;
          `SMCP_OP_WAKE: sleep_next = 1'b0;
          default: begin
            if (sr_write_go) begin
              // latch kept, every other bit from the host byte
              status_next = {data_reg[7:2], status_reg[`SMCP_BIT_WEL], data_reg[`SMCP_BIT_FREE]};
            end
          end
        endcase
      end
    end else begin
      if (sck_rise) begin
        bitcnt_next = bitcnt_reg + `SMCP_BIT_ONE;
        shin_next = byte_val;
        rise_seen_next = 1'b1;
        if (state_reg == smcp_pkg::ST_ARM) begin
          state_next = smcp_pkg::ST_IGNORE;
        end
      end
      if (byte_done) begin
        case (state_reg)
          smcp_pkg::ST_CMD: begin
            cmd_next = byte_val;
            if (sleep_reg) begin
              state_next = (byte_val == `SMCP_OP_WAKE) ? smcp_pkg::ST_ARM : smcp_pkg::ST_IGNORE;
            end else begin
              case (byte_val)
                `SMCP_OP_LATCH_SET, `SMCP_OP_LATCH_CLR, `SMCP_OP_SLEEP, `SMCP_OP_WAKE: state_next = smcp_pkg::ST_ARM;
                `SMCP_OP_STAT_RD: state_next = smcp_pkg::ST_SRD;
                `SMCP_OP_STAT_WR: state_next = smcp_pkg::ST_SWR;
                `SMCP_OP_MEM_RD, `SMCP_OP_MEM_WR: state_next = smcp_pkg::ST_ADDR;
                default: state_next = smcp_pkg::ST_IGNORE;
              endcase
            end
          end
          smcp_pkg::ST_SWR: begin
            data_next = byte_val;
            state_next = smcp_pkg::ST_ARM;
          end
          smcp_pkg::ST_ADDR: begin
            if (!ahi_reg) begin
              addr_next = {byte_val[6:0], addr_reg[7:0]};
              ahi_next = 1'b1;
            end else begin
              addr_next = {addr_reg[14:8], byte_val};
              state_next = (cmd_reg == `SMCP_OP_MEM_RD) ? smcp_pkg::ST_RDATA : smcp_pkg::ST_WDATA;
            end
          end
          smcp_pkg::ST_WDATA: begin
            if (status_reg[`SMCP_BIT_WEL] && !addr_guarded(status_reg[3:2], addr_reg)) begin
              push_v_next = 1'b1;
              push_data_next = '{addr: addr_reg, data: byte_val};
            end
            addr_next = addr_reg + `SMCP_ADDR_ONE;
          end
          default: state_next = state_reg;
        endcase
      end
      if (load_go) begin
        so_next = load_byte[7];
        shout_next = {load_byte[6:0], 1'b0};
        so_oe_next = 1'b1;
        if (state_reg == smcp_pkg::ST_RDATA) begin
          addr_next = addr_reg + `SMCP_ADDR_ONE;
        end
      end else if (sck_fall && so_oe_reg) begin
        so_next = shout_reg[7];
        shout_next = {shout_reg[6:0], 1'b0};
      end
    end
    if (power_restore_in) begin
      status_next[`SMCP_BIT_WEL] = 1'b0;
      sleep_next = 1'b0;
      state_next = smcp_pkg::ST_IDLE;
      so_oe_next = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= smcp_pkg::ST_IDLE;
      bitcnt_reg <= `SMCP_BIT_FIRST;
      shin_reg <= 8'h00;
      shout_reg <= 8'h00;
      cmd_reg <= 8'h00;
      data_reg <= 8'h00;
      addr_reg <= `SMCP_ADDR_ZERO;
      ahi_reg <= 1'b0;
      status_reg <= `SMCP_STATUS_RST;
      sleep_reg <= 1'b0;
      mode_reg <= 1'b0;
      rise_seen_reg <= 1'b0;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
      push_v_reg <= 1'b0;
      push_data_reg <= '0;
    end else begin
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      shin_reg <= shin_next;
      shout_reg <= shout_next;
      cmd_reg <= cmd_next;
      data_reg <= data_next;
      addr_reg <= addr_next;
      ahi_reg <= ahi_next;
      status_reg <= status_next;
      sleep_reg <= sleep_next;
      mode_reg <= mode_next;
      rise_seen_reg <= rise_seen_next;
      so_reg <= so_next;
      so_oe_reg <= so_oe_next;
      push_v_reg <= push_v_next;
      push_data_reg <= push_data_next;
    end
  end

  assign so_out = so_reg;
  assign so_oe_out = so_oe_reg;
  assign status_out = status_reg;
  assign sleep_out = sleep_reg;

  // =====================================================================
  // write buffer and array
  smcp_fifo #(
    .WIDTH(`SMCP_FIFO_W),
    .DEPTH(`SMCP_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .in_data_in(push_data_reg),
    .in_valid_in(push_v_reg),
    .in_ready_out(fifo_ready),
    .out_data_out(drain_word),
    .out_valid_out(drain_valid),
    .out_ready_in(drain_ready)
  );

  // array write port, no busy time
  always_ff @(posedge mclk_in) begin
    if (drain_valid && drain_ready) begin
      mem_reg[drain_word.addr] <= drain_word.data;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_latch_frame;
    exec_go && cmd_reg == `SMCP_OP_LATCH_SET;
  endsequence

  a_latch_set_frame: assert property (s_latch_frame |=> status_reg[`SMCP_BIT_WEL] || $past(power_restore_in))
    else $error("latch set frame did not set the write latch");
  a_latch_clear_go: assert property (power_restore_in || (exec_go && cmd_reg == `SMCP_OP_LATCH_CLR)
    |=> !status_reg[`SMCP_BIT_WEL])
    else $error("write latch not cleared");
  a_push_guarded: assert property ($rose(push_v_reg) |-> $past(status_reg[`SMCP_BIT_WEL])
    && !addr_guarded($past(status_reg[3:2]), push_data_reg.addr))
    else $error("array write queued while locked or protected");
  a_bit0_no_self: assert property ($changed(status_reg[`SMCP_BIT_FREE]) |-> $past(sr_write_go))
    else $error("bit 0 changed without a status write");
  a_sleep_ignores: assert property (sleep_reg && byte_done && state_reg == smcp_pkg::ST_CMD
    && byte_val != `SMCP_OP_WAKE && !power_restore_in |=> state_reg == smcp_pkg::ST_IGNORE)
    else $error("command accepted during sleep");
  a_power_wakes: assert property (power_restore_in |=> !sleep_reg && state_reg == smcp_pkg::ST_IDLE)
    else $error("sleep survived power restore");
  a_addr_wraps: assert property (byte_done && state_reg == smcp_pkg::ST_WDATA && addr_reg == `SMCP_ADDR_TOP
    && !power_restore_in |=> addr_reg == `SMCP_ADDR_ZERO)
    else $error("address did not wrap to zero");
  a_swd_locked: assert property (exec_go && cmd_reg == `SMCP_OP_STAT_WR && status_reg[`SMCP_BIT_SWD]
    && !filt_reg.wp_b |=> $stable(status_reg[7:2]))
    else $error("locked status bits changed");
  a_so_release: assert property (cs_rise |=> !so_oe_reg [*2])
    else $error("output still driven after chip select rose");
endmodule // smcp_top

// ==== rtl/smcp_defs.svh ====
// constants of the serial memory command and protection block
// assumes inclusion by every file that names an opcode, field or count
`ifndef SMCP_DEFS_SVH
`define SMCP_DEFS_SVH
// =====================================================================
// opcodes
`define SMCP_OP_LATCH_SET 8'h06
`define SMCP_OP_LATCH_CLR 8'h04
`define SMCP_OP_STAT_RD 8'h05
`define SMCP_OP_STAT_WR 8'h01
`define SMCP_OP_MEM_RD 8'h03
`define SMCP_OP_MEM_WR 8'h02
`define SMCP_OP_SLEEP 8'hB9
`define SMCP_OP_WAKE 8'hAB
// =====================================================================
// status register fields
`define SMCP_BIT_SWD 7
`define SMCP_BIT_BPH 3
`define SMCP_BIT_BPL 2
`define SMCP_BIT_WEL 1
`define SMCP_BIT_FREE 0
`define SMCP_STATUS_RST 8'h00
// =====================================================================
// array geometry and protection bounds
`define SMCP_ADDR_W 15
`define SMCP_MEM_DEPTH 32768
`define SMCP_ADDR_TOP 15'h7FFF
`define SMCP_ADDR_ZERO 15'h0000
`define SMCP_ADDR_ONE 15'h0001
`define SMCP_QUARTER_BASE 15'h6000
`define SMCP_HALF_BASE 15'h4000
`define SMCP_BP_NONE 2'h0
`define SMCP_BP_QUARTER 2'h1
`define SMCP_BP_HALF 2'h2
`define SMCP_FIFO_DEPTH 16
`define SMCP_FIFO_W 23
// =====================================================================
// bit counter
`define SMCP_BIT_FIRST 3'h0
`define SMCP_BIT_LAST 3'h7
`define SMCP_BIT_ONE 3'h1
`endif

// ==== rtl/smcp_pkg.sv ====
// types of the serial memory command and protection block
// assumes smcp_defs.svh is compiled alongside
package smcp_pkg;
  // =====================================================================
  // pin samples travelling through the synchroniser
  typedef struct packed {
    logic cs_b;
    logic sck;
    logic si;
    logic wp_b;
  } smcp_pins_type;

  // one array write waiting in the buffer
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } smcp_wr_type;

  // transaction phases
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_CMD = 9'h002,
    ST_ADDR = 9'h004,
    ST_WDATA = 9'h008,
    ST_RDATA = 9'h010,
    ST_SRD = 9'h020,
    ST_SWR = 9'h040,
    ST_ARM = 9'h080,
    ST_IGNORE = 9'h100
  } smcp_state_type;
endpackage

// ==== verif/smcp_host.sv ====
// host spi master model for the serial memory block
// assumes the bench clock paces it; every pin change lands on a falling edge
`timescale 1ns/10ps

// =====================================================================
// host model
module smcp_host (
  input wire logic mclk_in, // bench clock, pacing only
  input wire logic so_in, // resolved serial out line
  output logic cs_b_out, // chip select, active low
  output logic sck_out, // serial clock, still outside frames
  output logic si_out // serial data to the device
);
  logic [7:0] tx_q[$]; // bytes to send
  logic [7:0] rx_q[$]; // bytes seen on the out line
  // wait a number of falling edges
  task automatic hw(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // one frame: tx_q msb first, then extra partial bits; 160 ns per bit
  task automatic frame(input bit mode3, input int extra);
    int nb;
    logic [7:0] sh;
    nb = 8 * tx_q.size() + extra;
    rx_q.delete();
    sck_out = mode3;
    hw(2);
    cs_b_out = 1'b0;
    hw(4);
    for (int i = 0; i < nb; i++) begin
      sck_out = 1'b0;
      si_out = (i / 8 < tx_q.size()) ? tx_q[i / 8][7 - i % 8] : 1'b1;
      hw(4);
      sck_out = 1'b1;
      hw(4);
      sh = {sh[6:0], so_in};
      if (i % 8 == 7) begin
        rx_q.push_back(sh);
      end
    end
    sck_out = mode3;
    hw(4);
    cs_b_out = 1'b1;
    si_out = ~si_out; // a released line shows no stale copy
    hw(12);
  endtask
  // idle pins
  initial begin
    cs_b_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end
endmodule // smcp_host

// ==== verif/smcp_top_bench.sv ====
// self-checking bench of the serial memory command and protection block
// assumes smcp_top and the host model; a status, sleep and array model predicts every result
`timescale 1ns/10ps

// =====================================================================
// bench top
module smcp_top_bench;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic power_restore_in = 1'b0;
  logic wp_b_in = 1'b1;
  logic cs_b, sck, si, so_out, so_oe_out, sleep_out, so_line;
  logic [7:0] status_out;
  int n_fail = 0;
  int checked = 0;
  logic [15:0] lfsr = 16'hF663;
  logic [15:0] r;
  logic [7:0] m_st = 8'h00; // model status byte
  logic m_sleep = 1'b0; // model sleep flag
  logic [7:0] m_mem [int]; // model array
  bit mode3 = 1'b0;
  logic [14:0] ad [6] = '{15'h3FFF, 15'h4000, 15'h5FFF, 15'h6000, 15'h7FFF, 15'h0000};
  // clock and the out line, which is never left clean when undriven
  always #10 mclk_in = ~mclk_in;
  assign so_line = so_oe_out ? so_out : ~so_out;
  smcp_top dut_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .power_restore_in(power_restore_in),
    .cs_b_in(cs_b), .sck_in(sck), .si_in(si), .wp_b_in(wp_b_in), .so_out(so_out),
    .so_oe_out(so_oe_out), .status_out(status_out), .sleep_out(sleep_out));
  smcp_host host_u (.mclk_in(mclk_in), .so_in(so_line), .cs_b_out(cs_b), .sck_out(sck), .si_out(si));
  // =====================================================================
  // helpers
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp || $isunknown(got)) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic bit prot(input logic [14:0] a);
    case (m_st[3:2])
      2'h0: return 1'b0;
      2'h1: return a >= 15'h6000;
      2'h2: return a >= 15'h4000;
      default: return 1'b1;
    endcase
  endfunction
  // send a frame, advance the model, compare read bytes and flags
  task automatic fr(input logic [7:0] b[$], input int extra);
    logic [14:0] a;
    int n;
    n = b.size();
    a = (n > 2) ? {b[1][6:0], b[2]} : 15'h0000;
    host_u.tx_q = b;
    mode3 = ~mode3;
    host_u.frame(mode3, extra);
    if (m_sleep) begin
      if (extra == 0 && n == 1 && b[0] == 8'hAB) m_sleep = 1'b0;
    end else if (extra == 0) begin
      case (b[0])
        8'h06: if (n == 1) m_st[1] = 1'b1;
        8'h04: if (n == 1) m_st[1] = 1'b0;
        8'hB9: if (n == 1) m_sleep = 1'b1;
        8'h01: if (n == 2 && m_st[1] && (!m_st[7] || wp_b_in)) m_st = {b[1][7:2], m_st[1], b[1][0]};
        8'h05: for (int i = 1; i < n; i++) chk(16'(host_u.rx_q[i]), 16'(m_st));
        8'h03: for (int i = 3; i < n; i++) begin
          chk(16'(host_u.rx_q[i]), 16'(m_mem[a]));
          a++;
        end
        8'h02: for (int i = 3; i < n; i++) begin
          if (m_st[1] && !prot(a)) m_mem[a] = b[i];
          a++;
        end
        default: ;
      endcase
    end
    chk(16'(status_out), 16'(m_st));
    chk(16'(sleep_out), 16'(m_sleep));
    chk(16'(so_oe_out), 16'h0000);
  endtask
  task automatic done(input string s);
    $display("test %s ended", s);
  endtask
  task automatic finish_test();
    $display("counts: checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // =====================================================================
  // watchdog cuts a hang short
  initial begin
    repeat (90000) @(posedge mclk_in);
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (3) @(negedge mclk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk(16'(status_out), 16'h0000);
    fr('{8'h05, 8'h00, 8'h00}, 0);
    done("reset");
    fr('{8'h06}, 0);
    r = rnd();
    fr('{8'h02, 8'hFF, 8'hFE, r[7:0], r[15:8], 8'h3C}, 0);
    for (int bp = 0; bp < 4; bp++) begin
      r = rnd();
      fr('{8'h01, {1'b0, r[6:4], 2'(bp), 1'b0, r[0]}}, 0);
      for (int k = 0; k < 6; k++) begin
        r = rnd();
        fr('{8'h02, {1'b0, ad[k][14:8]}, ad[k][7:0], r[7:0]}, 0);
        fr('{8'h03, {r[8], ad[k][14:8]}, ad[k][7:0], 8'h00}, 0);
      end
    end
    fr('{8'h03, 8'h7F, 8'hFE, 8'h00, 8'h00, 8'h00}, 0);
    fr('{8'h01, 8'h00}, 0);
    done("protect");
    fr('{8'h04}, 0);
    fr('{8'h02, 8'h3F, 8'hFF, 8'h5A}, 0);
    fr('{8'h01, 8'h0C}, 0);
    fr('{8'h03, 8'h3F, 8'hFF, 8'h00}, 0);
    done("latch");
    fr('{8'h06}, 0);
    fr('{8'h01, 8'h80}, 0);
    wp_b_in = 1'b0;
    fr('{8'h01, 8'h8C}, 0);
    wp_b_in = 1'b1;
    fr('{8'h01, 8'h0D}, 0);
    fr('{8'h01, 8'h00}, 0);
    done("lock");
    fr('{8'h04}, 0);
    fr('{8'h06}, 5);
    fr('{8'h06, 8'h00}, 0);
    fr('{8'h5A}, 0);
    done("junk");
    fr('{8'hB9}, 0);
    fr('{8'h06}, 0);
    fr('{8'h05, 8'h00}, 0);
    fr('{8'hAB}, 0);
    fr('{8'h06}, 0);
    fr('{8'hB9}, 0);
    power_restore_in = 1'b1;
    @(negedge mclk_in);
    power_restore_in = 1'b0;
    m_st[1] = 1'b0;
    m_sleep = 1'b0;
    repeat (3) @(negedge mclk_in);
    fr('{8'h05, 8'h00}, 0);
    chk(16'(status_out), 16'(m_st));
    done("sleep");
    rst_b_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    rst_b_in = 1'b1;
    m_st = 8'h00;
    repeat (4) @(negedge mclk_in);
    fr('{8'h05, 8'h00}, 0);
    done("rereset");
    finish_test();
  end
endmodule // smcp_top_bench
